//--- rtl/mmdia_defines.vh
// Constants for the indirect extended register access block
`ifndef MMDIA_DEFINES_VH
`define MMDIA_DEFINES_VH
`define MMDIA_ADDR_CTRL 5'h0d
`define MMDIA_ADDR_WIN 5'h0e
`define MMDIA_FN_HI 15
`define MMDIA_FN_LO 14
`define MMDIA_DEV_HI 4
`define MMDIA_DEV_LO 0
`define MMDIA_FN_ADDR 2'h0
`define MMDIA_FN_DATA 2'h1
`define MMDIA_FN_INC_RW 2'h2
`define MMDIA_FN_INC_W 2'h3
`define MMDIA_DEV_VENDOR 5'h1f
`define MMDIA_CLKCFG_ADDR 16'h0170
`define MMDIA_CLKCFG_RST 16'h0c10
`define MMDIA_CLKOFF_BIT 6
`define MMDIA_CTRL_RST 16'h0000
`define MMDIA_PTR_RST 16'h0000
`endif

//--- rtl/mmdia_indirect_access.v
// Indirect extended register window behind the direct management registers
`timescale 1ns/1ps
`include "mmdia_defines.vh"
module mmdia_indirect_access #(
    parameter EXT_AW = 4
) (
    input wire core_clk,
    input wire rst,
    input wire reg_wr,
    input wire reg_rd,
    input wire [4:0] reg_addr,
    input wire [15:0] reg_wdata,
    output reg [15:0] reg_rdata,
    output wire reg_hit,
    output wire clk_out_en
);
    localparam EXT_N = 1 << EXT_AW;
    reg [15:0] ctrl_q;
    reg [15:0] ptr_q;
    reg [15:0] ext_q [0:EXT_N-1];
    reg [15:0] clkcfg_q;
    wire [1:0] fn = ctrl_q[`MMDIA_FN_HI:`MMDIA_FN_LO];
    wire dev_ok = ctrl_q[`MMDIA_DEV_HI:`MMDIA_DEV_LO] == `MMDIA_DEV_VENDOR;
    // Only the direct bus reaches these two; the window never aliases onto them
    wire sel_ctrl = reg_addr == `MMDIA_ADDR_CTRL;
    wire sel_win = reg_addr == `MMDIA_ADDR_WIN;
    wire win_wr = reg_wr && sel_win && dev_ok;
    wire win_rd = reg_rd && sel_win && dev_ok;
    wire is_clkcfg = ptr_q == `MMDIA_CLKCFG_ADDR;
    wire [EXT_AW-1:0] idx = ptr_q[EXT_AW-1:0];
    // The pointer may name the direct control or window address; those stay unreachable
    wire ptr_alias = (ptr_q == {{11{1'b0}}, `MMDIA_ADDR_CTRL}) ||
        (ptr_q == {{11{1'b0}}, `MMDIA_ADDR_WIN});
    wire ptr_in_ram = (ptr_q[15:EXT_AW] == {(16-EXT_AW){1'b0}}) && !ptr_alias;
    wire data_wr = win_wr && fn != `MMDIA_FN_ADDR;
    wire inc = (data_wr && fn[1]) || (win_rd && fn == `MMDIA_FN_INC_RW);
    integer i;
    assign reg_hit = sel_ctrl || sel_win;
    // Extended clock output gated by the clock config register
    assign clk_out_en = ~clkcfg_q[`MMDIA_CLKOFF_BIT];
    always @(posedge core_clk) begin
        if (rst) begin
            ctrl_q <= `MMDIA_CTRL_RST;
        end else if (reg_wr && sel_ctrl) begin
            ctrl_q <= reg_wdata;
        end
    end
    // Pointer survives code changes; moves only on load or increment
    always @(posedge core_clk) begin
        if (rst) begin
            ptr_q <= `MMDIA_PTR_RST;
        end else if (win_wr && fn == `MMDIA_FN_ADDR) begin
            ptr_q <= reg_wdata;
        end else if (inc) begin
            ptr_q <= ptr_q + 16'h0001;
        end
    end
    always @(posedge core_clk) begin
        if (rst) begin
            clkcfg_q <= `MMDIA_CLKCFG_RST;
            for (i = 0; i < EXT_N; i = i + 1) begin
                ext_q[i] <= 16'h0000;
            end
        end else if (data_wr) begin
            if (is_clkcfg) begin
                clkcfg_q <= reg_wdata;
            end else if (ptr_in_ram) begin
                ext_q[idx] <= reg_wdata;
            end
        end
    end
    // Unimplemented extended addresses read zero and drop writes
    always @(posedge core_clk) begin
        if (rst) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            if (sel_ctrl) begin
                reg_rdata <= ctrl_q;
            end else if (win_rd && fn == `MMDIA_FN_ADDR) begin
                reg_rdata <= ptr_q;
            end else if (win_rd && is_clkcfg) begin
                reg_rdata <= clkcfg_q;
            end else if (win_rd && ptr_in_ram) begin
                reg_rdata <= ext_q[idx];
            end else begin
                reg_rdata <= 16'h0000;
            end
        end
    end
endmodule // mmdia_indirect_access

//--- verif/mmdia_asserts.sv
// Checker on the block ports
`timescale 1ns/1ps
module mmdia_chk (input wire core_clk, rst, reg_rd, reg_wr, reg_hit, clk_out_en,
    input wire [4:0] reg_addr, input wire [15:0] reg_wdata, input wire [15:0] reg_rdata);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence s_ctrl_wr;
        reg_wr && reg_addr == 5'h0d;
    endsequence
    sequence s_ctrl_rd;
        reg_rd && reg_addr == 5'h0d;
    endsequence
    AST_CTRL_RB: assert property (s_ctrl_wr ##1 (!reg_wr && !reg_rd) ##1 s_ctrl_rd |=> reg_rdata == $past(reg_wdata, 3)) else $error("control readback");
    AST_RD_HOLD: assert property (!reg_rd |=> $stable(reg_rdata)) else $error("read data moved");
    AST_CTRL_CLK: assert property (s_ctrl_wr |=> $stable(clk_out_en)) else $error("control write moved clock");
    AST_HIT: assert property (reg_hit == (reg_addr inside {5'h0d, 5'h0e})) else $error("hit");
    AST_MISS: assert property (reg_rd && !reg_hit |=> !reg_rdata) else $error("miss");
    AST_CLK: assert property (!reg_wr |=> $stable(clk_out_en)) else $error("clk");
endmodule // mmdia_chk
bind mmdia_indirect_access mmdia_chk u_chk (.*);

//--- verif/mmdia_sta.sv
// Station model issuing direct register strobes
`timescale 1ns/1ps
module mmdia_sta (input wire core_clk, output reg reg_wr = '0, reg_rd = '0,
    output reg [4:0] reg_addr = '0, output reg [15:0] reg_wdata = '0);
    task xfer(input bit w, input [4:0] a, input [15:0] d);
        @(negedge core_clk) {reg_wr, reg_rd, reg_addr, reg_wdata} <= {w, !w, a, d};
        @(negedge core_clk) {reg_wr, reg_rd} <= 2'h0;
    endtask
endmodule // mmdia_sta

//--- verif/mmdia_indirect_access_bench.sv
// Bench for the indirect access block
`timescale 1ns/1ps
module mmdia_indirect_access_bench;
    logic core_clk = 1'h0, rst = 1'h1, reg_wr, reg_rd, reg_hit, clk_out_en;
    logic [4:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, d [5], eq [$];
    logic [21:0] pa [13] = '{22'h0e_0000, 22'h00_0000, 22'h2d_001f, 22'h0d_001f, 22'h2e_0170,
        22'h0e_0170,
        22'h2d_401f, 22'h0e_0c10, 22'h0e_0c10, 22'h2e_0c50, 22'h2d_001f, 22'h2e_0000, 22'h2d_c01f};
    logic [21:0] pb [4] = '{22'h2d_001f, 22'h0e_0005, 22'h2e_0000, 22'h2d_801f};
    // Pointer aimed at the window address: writes dropped, reads zero, control untouched
    logic [21:0] pc [6] = '{22'h2d_001f, 22'h2e_000e, 22'h2d_401f, 22'h2e_1234, 22'h0e_0000,
        22'h0d_401f};
    int n_mismatch = 0, tests_run = 0;
    initial forever #4 core_clk = ~core_clk;
    mmdia_indirect_access dut (.*);
    mmdia_sta sta (.*);
    task chk(input logic [15:0] s, e);
        tests_run++;
        n_mismatch += (s !== e);
        if (s !== e) $display("wrong value at %0t: %h %h", $time, s, e);
    endtask
    // Reads queue their expectation before the strobe goes out
    task t(input logic [21:0] o);
        if (!o[21]) eq.push_back(o[15:0]);
        sta.xfer(o[21], o[20:16], o[15:0]);
    endtask
    task wrap_up;
        if (n_mismatch == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(negedge core_clk) if (reg_rd === 1'h1) chk(reg_rdata, eq.pop_front());
    initial #20us begin n_mismatch++; wrap_up; end
    initial begin
        foreach (d[i]) d[i] = i ? $urandom : $urandom(95);
        #128 rst = 1'h0;
        foreach (pa[i]) t(pa[i]);
        chk({15'h0000, clk_out_en}, 16'h0000);
        foreach (d[i]) t({6'h2e, d[i]});
        foreach (pb[i]) t(pb[i]);
        for (int i = 0; i < 4; i++) t({6'h0e, d[i]});
        t(22'h2d_c01f);
        // Write-increment code does not advance the pointer on reads, so both reads hit the same place
        repeat (2) t({6'h0e, d[4]});
        foreach (pc[i]) t(pc[i]);
        wrap_up;
    end
endmodule // mmdia_indirect_access_bench
